// ---- fpr_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

module fpr_ctrl
    import fpr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_device_reset_n,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rx_word_valid,
    input wire logic [CHAR_W-1:0] i_rx_word,
    input wire logic [7:0] i_dec_byte,
    input wire logic [2:0] i_dec_status,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte_in,
    input wire logic [1:0] i_tx_char_type,
    input wire logic i_tx_parity_in,
    output logic o_rx_valid,
    output logic [CHAR_W-1:0] o_rx_char,
    output logic [7:0] o_rx_byte_out,
    output logic [2:0] o_rx_char_status,
    output logic o_rx_parity_out,
    output logic o_rx_parity_out_oe,
    output logic o_tx_parity_err,
    output logic [1:0] o_pll_range,
    output logic o_tx_half_rate,
    output logic o_buf_ptr_init,
    output logic o_self_test,
    output logic o_output_enable,
    output logic o_rx_latch,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic rst_s1_q;
    logic rst_s2_q;
    logic in_rst;
    logic [3:0] settle_q;
    logic ready_q;
    fpr_cfg_t cfg_q;
    fpr_cfg_t act_q;
    logic [2:0] ctrl_q;
    logic [2:0] irq_st_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic wait_q;
    logic wr_acc;
    logic [CHAR_W-1:0] prev_q;
    logic [2*CHAR_W-1:0] hist;
    logic [CHAR_W-1:0] hits;
    logic hit_any;
    logic [3:0] hit_off;
    logic [3:0] off_q;
    logic realign_q;
    logic cand_valid_q;
    logic [3:0] cand_off_q;
    logic [2:0] cand_age_q;
    logic [3:0] run_off_q;
    logic [2:0] run_cnt_q;
    logic low_realign;
    logic [CHAR_W-1:0] aligned;
    fpr_rx_t rx_d;
    logic rx_par_d;
    logic tx_odd;
    logic tx_err;
    logic bad_rate;
    logic bad_rate_q;

    // Lowest offset holding a framing character
    function automatic logic [3:0] first_hit(input logic [CHAR_W-1:0] h);
        logic [3:0] r;
        r = 4'h0;
        for (int i = CHAR_W - 1; i >= 0; i--) begin
            if (h[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Byte-lane merge of a bus write
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Device reset pin

    // Pin is asynchronous to i_clk, so two flops before use
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= i_device_reset_n;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign in_rst = !rst_s2_q;

    // Settle count after release; outputs are already cleared, ready just reports it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            settle_q <= 4'h0;
            ready_q <= 1'b0;
        end else if (in_rst) begin
            settle_q <= 4'h0;
            ready_q <= 1'b0;
        end else begin
            if (settle_q != SETTLE_CYC) begin
                settle_q <= settle_q + 4'h1;
            end
            ready_q <= (settle_q == SETTLE_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    assign wr_acc = i_avs_write && !wait_q;

    // One wait cycle per access; read data latched as waitrequest drops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_q <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            wait_q <= !((i_avs_read || i_avs_write) && wait_q);
            if (i_avs_read && wait_q) begin
                case (i_avs_address)
                    OFF_CONFIG: o_avs_readdata <= {21'h0, cfg_q};
                    OFF_CONTROL: o_avs_readdata <= {29'h0, ctrl_q};
                    OFF_STATUS: o_avs_readdata <= {25'h0, bad_rate_q, in_rst, ready_q, off_q};
                    OFF_IRQ_STAT: o_avs_readdata <= {29'h0, irq_st_q};
                    OFF_IRQ_MASK: o_avs_readdata <= {29'h0, irq_mask_q};
                    default: o_avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_avs_waitrequest = wait_q;

    // Written selects wait here until device reset is held
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_q <= fpr_cfg_t'(CFG_RESET);
        end else if (wr_acc && i_avs_address == OFF_CONFIG) begin
            cfg_q <= fpr_cfg_t'(CFG_W'(be_merge({21'h0, cfg_q}, i_avs_writedata, i_avs_byteenable)));
        end
    end

    // Active selects follow only under reset, so they stay static in operation
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            act_q <= fpr_cfg_t'(CFG_RESET);
        end else if (in_rst) begin
            act_q <= cfg_q;
        end
    end

    // Self-test, output-enable and receive latches
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (in_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_acc && i_avs_address == OFF_CONTROL && i_avs_byteenable[0]) begin
            ctrl_q <= i_avs_writedata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    assign irq_set = {bad_rate && !bad_rate_q, realign_q, tx_err};
    assign irq_clr = (wr_acc && i_avs_address == OFF_IRQ_STAT && i_avs_byteenable[0])
                     ? i_avs_writedata[2:0] : 3'h0;

    // Write one to clear; a same-cycle event wins
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_st_q <= IRQ_RESET;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_mask_q <= IRQ_RESET;
        end else if (wr_acc && i_avs_address == OFF_IRQ_MASK && i_avs_byteenable[0]) begin
            irq_mask_q <= i_avs_writedata[2:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_st_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Framer

    assign hist = {i_rx_word, prev_q};

    // One comparator per bit offset, both disparities accepted
    genvar k;
    generate
        for (k = 0; k < CHAR_W; k++) begin : g_hit
            assign hits[k] = i_rx_word_valid && (hist[k +: CHAR_W] == COMMA_NEG
                                                 || hist[k +: CHAR_W] == COMMA_POS);
        end
    endgenerate

    assign hit_any = |hits;
    assign hit_off = first_hit(hits);
    assign aligned = hist[off_q +: CHAR_W];
    assign low_realign = act_q.framing == SEL_LOW && hit_any && hit_off != off_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_q <= 10'h000;
        end else if (in_rst) begin
            prev_q <= 10'h000;
        end else if (i_rx_word_valid) begin
            prev_q <= i_rx_word;
        end
    end

    // Alignment tracking per framing mode
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            off_q <= 4'h0;
            realign_q <= 1'b0;
            cand_valid_q <= 1'b0;
            cand_off_q <= 4'h0;
            cand_age_q <= 3'h0;
            run_off_q <= 4'h0;
            run_cnt_q <= 3'h0;
        end else if (in_rst) begin
            off_q <= 4'h0;
            realign_q <= 1'b0;
            cand_valid_q <= 1'b0;
            cand_off_q <= 4'h0;
            cand_age_q <= 3'h0;
            run_off_q <= 4'h0;
            run_cnt_q <= 3'h0;
        end else begin
            realign_q <= 1'b0;
            // Candidate ages out once a partner could no longer fit in the window
            if (i_rx_word_valid && cand_valid_q) begin
                cand_age_q <= cand_age_q + 3'h1;
                if (cand_age_q + 3'h1 == SPAN_GAP) begin
                    cand_valid_q <= 1'b0;
                end
            end
            case (act_q.framing)
                SEL_LOW: begin
                    if (low_realign) begin
                        off_q <= hit_off;
                        realign_q <= 1'b1;
                    end
                end
                SEL_MID: begin
                    if (hit_any && hit_off != off_q) begin
                        if (cand_valid_q && cand_off_q == hit_off) begin
                            off_q <= hit_off;
                            realign_q <= 1'b1;
                            cand_valid_q <= 1'b0;
                        end else begin
                            cand_valid_q <= 1'b1;
                            cand_off_q <= hit_off;
                            cand_age_q <= 3'h0;
                        end
                    end
                end
                SEL_HIGH: begin
                    if (hit_any) begin
                        if (run_cnt_q != 3'h0 && run_off_q == hit_off) begin
                            if (run_cnt_q != HIGH_RUN) begin
                                run_cnt_q <= run_cnt_q + 3'h1;
                            end
                            if (run_cnt_q + 3'h1 == HIGH_RUN && hit_off != off_q) begin
                                off_q <= hit_off;
                                realign_q <= 1'b1;
                            end
                        end else begin
                            run_off_q <= hit_off;
                            run_cnt_q <= 3'h1;
                        end
                    end else if (i_rx_word_valid) begin
                        run_cnt_q <= 3'h0;
                    end
                end
                default: begin
                    realign_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive output and parity

    // Decoder bypass hands raw character bits straight on
    always_comb begin
        if (act_q.dec == SEL_LOW) begin
            rx_d = {1'b0, aligned};
        end else begin
            rx_d = {i_dec_status, i_dec_byte};
        end
        case (act_q.parity)
            SEL_MID: rx_par_d = (act_q.dec != SEL_LOW) ? ~^rx_d.data
                                : ~^{rx_d.status[1:0], rx_d.data};
            SEL_HIGH: rx_par_d = ~^{rx_d.status, rx_d.data};
            default: rx_par_d = 1'b0;
        endcase
    end

    // Only the low-latency framer drops a beat, stretching the character clock
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_valid <= 1'b0;
            o_rx_char <= 10'h000;
            o_rx_byte_out <= 8'h00;
            o_rx_char_status <= 3'h0;
            o_rx_parity_out <= 1'b0;
            o_rx_parity_out_oe <= 1'b0;
        end else if (in_rst) begin
            o_rx_valid <= 1'b0;
            o_rx_char <= 10'h000;
            o_rx_byte_out <= 8'h00;
            o_rx_char_status <= 3'h0;
            o_rx_parity_out <= 1'b0;
            o_rx_parity_out_oe <= 1'b0;
        end else begin
            o_rx_valid <= i_rx_word_valid && !low_realign;
            o_rx_char <= aligned;
            o_rx_byte_out <= rx_d.data;
            o_rx_char_status <= rx_d.status;
            o_rx_parity_out <= rx_par_d;
            o_rx_parity_out_oe <= act_q.parity != SEL_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit parity check

    always_comb begin
        case (act_q.parity)
            SEL_MID: tx_odd = (act_q.enc != SEL_LOW) ? ^{i_tx_byte_in, i_tx_parity_in}
                              : ^{i_tx_char_type, i_tx_byte_in, i_tx_parity_in};
            SEL_HIGH: tx_odd = ^{i_tx_char_type, i_tx_byte_in, i_tx_parity_in};
            default: tx_odd = 1'b1;
        endcase
    end

    assign tx_err = i_tx_valid && !in_rst && !tx_odd;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_parity_err <= 1'b0;
        end else begin
            o_tx_parity_err <= tx_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate, latches and buffer pointer init

    // Half rate with the low range is illegal; refuse it rather than misclock the PLL
    assign bad_rate = act_q.rate == SEL_LOW && act_q.tx_half_rate;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bad_rate_q <= 1'b0;
            o_pll_range <= SEL_LOW;
            o_tx_half_rate <= 1'b0;
            o_buf_ptr_init <= 1'b1;
            o_self_test <= 1'b0;
            o_output_enable <= 1'b0;
            o_rx_latch <= 1'b0;
        end else begin
            bad_rate_q <= bad_rate;
            o_pll_range <= act_q.rate;
            o_tx_half_rate <= act_q.tx_half_rate && !bad_rate;
            o_buf_ptr_init <= in_rst;
            o_self_test <= ctrl_q[CTRL_SELF_TEST];
            o_output_enable <= ctrl_q[CTRL_OUT_EN];
            o_rx_latch <= ctrl_q[CTRL_RX_LATCH];
        end
    end

endmodule // fpr_ctrl

`default_nettype wire

// ---- fpr_ctrl_properties.sv ----
`timescale 1ns/1ns
`default_nettype none

module fpr_ctrl_properties
    import fpr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_device_reset_n,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte_in,
    input wire logic [1:0] i_tx_char_type,
    input wire logic i_tx_parity_in,
    input wire logic o_rx_valid,
    input wire logic [7:0] o_rx_byte_out,
    input wire logic [2:0] o_rx_char_status,
    input wire logic o_rx_parity_out,
    input wire logic o_rx_parity_out_oe,
    input wire logic o_tx_parity_err,
    input wire logic [1:0] o_pll_range,
    input wire logic o_tx_half_rate,
    input wire logic o_buf_ptr_init,
    input wire logic o_self_test,
    input wire logic o_output_enable,
    input wire logic o_rx_latch
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    ////////////////////////////////////////////////////////////////////////
    // Parity path
    property p_par_off;
        !o_rx_parity_out_oe && !o_buf_ptr_init |-> !o_tx_parity_err && !o_rx_parity_out;
    endproperty
    a_par_off: assert property (p_par_off) else $error("parity active while off");
    // Mode unseen here: any of three sets
    property p_rx_par;
        o_rx_valid && o_rx_parity_out_oe |-> o_rx_parity_out == ~^o_rx_byte_out
            || o_rx_parity_out == ~^{o_rx_char_status[1:0], o_rx_byte_out}
            || o_rx_parity_out == ~^{o_rx_char_status, o_rx_byte_out};
    endproperty
    a_rx_par: assert property (p_rx_par) else $error("rx parity not odd");
    // Odd either way: no mode flags it
    property p_tx_ok;
        i_tx_valid && (^{i_tx_byte_in, i_tx_parity_in}) && !(^i_tx_char_type) |=> !o_tx_parity_err;
    endproperty
    a_tx_ok: assert property (p_tx_ok) else $error("good tx parity flagged");
    property p_tx_cause;
        o_tx_parity_err |-> $past(i_tx_valid);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("tx flag without input");

    ////////////////////////////////////////////////////////////////////////
    // Rate and reset
    property p_rate;
        o_pll_range != 2'h3 && (o_tx_half_rate -> o_pll_range != SEL_LOW);
    endproperty
    a_rate: assert property (p_rate) else $error("bad rate output");
    property p_buf_init;
        !i_device_reset_n [*4] |-> o_buf_ptr_init;
    endproperty
    a_buf_init: assert property (p_buf_init) else $error("pointer init missing");
    property p_latches;
        o_buf_ptr_init && $past(o_buf_ptr_init) |-> !o_self_test && !o_output_enable && !o_rx_latch;
    endproperty
    a_latches: assert property (p_latches) else $error("latch kept in reset");
    property p_rx_quiet;
        o_buf_ptr_init && $past(o_buf_ptr_init) |-> !o_rx_valid && !o_rx_parity_out_oe;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("rx active in reset");
    property p_release;
        $rose(i_device_reset_n) |-> ##[1:16] !o_buf_ptr_init;
    endproperty
    a_release: assert property (p_release) else $error("slow reset release");

    c_tx_err: cover property (o_tx_parity_err);
    c_rx_par: cover property (o_rx_valid && o_rx_parity_out_oe);
    c_release: cover property ($fell(o_buf_ptr_init));
endmodule // fpr_ctrl_properties

bind fpr_ctrl fpr_ctrl_properties i_fpr_ctrl_properties (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_device_reset_n(i_device_reset_n), .i_tx_valid(i_tx_valid),
    .i_tx_byte_in(i_tx_byte_in), .i_tx_char_type(i_tx_char_type), .i_tx_parity_in(i_tx_parity_in),
    .o_rx_valid(o_rx_valid), .o_rx_byte_out(o_rx_byte_out), .o_rx_char_status(o_rx_char_status),
    .o_rx_parity_out(o_rx_parity_out), .o_rx_parity_out_oe(o_rx_parity_out_oe),
    .o_tx_parity_err(o_tx_parity_err), .o_pll_range(o_pll_range), .o_tx_half_rate(o_tx_half_rate),
    .o_buf_ptr_init(o_buf_ptr_init), .o_self_test(o_self_test), .o_output_enable(o_output_enable),
    .o_rx_latch(o_rx_latch));

`default_nettype wire

// ---- fpr_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module fpr_ctrl_tb
    import fpr_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic dev_rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0, wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic wait_req;
    logic rx_wv, tx_v, tx_p, rx_v, rx_p, rx_oe, tx_err, half, bufi, st, oen, rxl, irq;
    logic [9:0] rx_w, rx_c;
    logic [7:0] dec_b, tx_b, rx_b;
    logic [2:0] dec_s, rx_s;
    logic [1:0] tx_t, pll;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 i_clk = ~i_clk;

    fpr_ctrl i_fpr_ctrl (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_device_reset_n(dev_rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_rx_word_valid(rx_wv), .i_rx_word(rx_w),
        .i_dec_byte(dec_b), .i_dec_status(dec_s), .i_tx_valid(tx_v), .i_tx_byte_in(tx_b),
        .i_tx_char_type(tx_t), .i_tx_parity_in(tx_p), .o_rx_valid(rx_v), .o_rx_char(rx_c),
        .o_rx_byte_out(rx_b), .o_rx_char_status(rx_s), .o_rx_parity_out(rx_p), .o_rx_parity_out_oe(rx_oe),
        .o_tx_parity_err(tx_err), .o_pll_range(pll), .o_tx_half_rate(half), .o_buf_ptr_init(bufi),
        .o_self_test(st), .o_output_enable(oen), .o_rx_latch(rxl), .o_irq(irq));

    fpr_host_model i_fpr_host_model (
        .i_clk(i_clk), .o_rx_word_valid(rx_wv), .o_rx_word(rx_w), .o_dec_byte(dec_b), .o_dec_status(dec_s),
        .o_tx_valid(tx_v), .o_tx_byte(tx_b), .o_tx_char_type(tx_t), .o_tx_parity(tx_p));

    ////////////////////////////////////////////////////////////////////////
    // Common tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    // Held until waitrequest sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        @(posedge i_clk);
        while (wait_req !== 1'b0) @(posedge i_clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q & m, e);
    endtask

    // Selects change under device reset
    task automatic set_cfg(input fpr_cfg_t c);
        logic [31:0] q;
        int n;
        bus(1'b1, OFF_CONTROL, 32'h7, q);
        repeat (2) @(posedge i_clk);
        check({rxl, oen, st}, 3'h7);
        dev_rst_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        bus(1'b1, OFF_CONFIG, 32'(c), q);
        repeat (4) @(posedge i_clk);
        check(bufi, 1'b1);
        check({rxl, oen, st}, 3'h0);
        dev_rst_n <= 1'b1;
        n = 0;
        while (bufi !== 1'b0 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        check(n < 16, 1'b1);
        repeat (20) @(posedge i_clk);
        rdchk(OFF_STATUS, 32'h10, 32'h10);
        check(pll, c.rate);
        check(half, c.tx_half_rate && c.rate != SEL_LOW);
        check(rx_oe, c.parity != SEL_LOW);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_vals();
        rdchk(OFF_CONFIG, 32'h7FF, CFG_RESET);
        rdchk(OFF_CONTROL, 32'h7, CTRL_RESET);
        rdchk(OFF_IRQ_MASK, 32'h7, IRQ_RESET);
        rdchk(5'h14, 32'hFFFFFFFF, 32'h0);
    endtask

    // Tx check and rx parity for one setting
    task automatic t_parity(input fpr_sel_t p, input logic on);
        fpr_sel_t m;
        logic [31:0] q;
        logic bad, any;
        logic [7:0] b;
        logic [2:0] s;
        m = on ? SEL_MID : SEL_LOW;
        set_cfg('{1'b0, SEL_MID, m, m, p, SEL_MID});
        any = 1'b0;
        for (int i = 0; i < 4; i++) begin
            i_fpr_host_model.send_tx(8'h0B, 2'(i), i[0]);
            bad = (p == SEL_MID && on) ? !(^{8'h0B, i[0]}) : !(^{8'h0B, 2'(i), i[0]});
            bad = bad && p != SEL_LOW;
            any = any | bad;
            @(posedge i_clk);
            check(tx_err, bad);
        end
        rdchk(OFF_IRQ_STAT, 32'h1, any);
        bus(1'b1, OFF_IRQ_STAT, 32'h1, q);
        rdchk(OFF_IRQ_STAT, 32'h1, 32'h0);
        i_fpr_host_model.send_burst(10'h155, 2, 8'h33, 3'h4);
        @(posedge i_clk);
        b = on ? 8'h33 : 8'h55;
        s = on ? 3'h4 : 3'h1;
        check({rx_c, rx_b, rx_s}, {10'h155, b, s});
        check(rx_p, p == SEL_LOW ? 1'b0 : p == SEL_HIGH ? ~^{s, b} : on ? ~^b : ~^{s[1:0], b});
    endtask

    // Word 347 repeated: k words hold k-1 commas
    task automatic t_frame(input fpr_sel_t f, input int k, input logic hit);
        logic [31:0] q;
        int n;
        set_cfg('{1'b0, SEL_MID, SEL_MID, SEL_MID, SEL_LOW, f});
        bus(1'b1, OFF_IRQ_MASK, 32'h2, q);
        n = 0;
        fork
            i_fpr_host_model.send_burst(10'h347, k, 8'h00, 3'h0);
            repeat (k + 3) begin
                @(posedge i_clk);
                n += (rx_v === 1'b1);
            end
        join
        check(n, k - (f == SEL_LOW && hit));
        rdchk(OFF_STATUS, 32'hF, hit ? 32'h5 : 32'h0);
        rdchk(OFF_IRQ_STAT, 32'h2, hit ? 32'h2 : 32'h0);
        check(irq, hit);
        bus(1'b1, OFF_IRQ_MASK, 32'h0, q);
        repeat (2) @(posedge i_clk);
        check(irq, 1'b0);
        bus(1'b1, OFF_IRQ_STAT, 32'h2, q);
        rdchk(OFF_IRQ_STAT, 32'h2, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        dev_rst_n <= 1'b1;
        t_reset_vals();
        for (int r = 0; r < 3; r++) begin
            set_cfg('{r != 0, fpr_sel_t'(2'(r)), SEL_MID, SEL_MID, SEL_MID, SEL_LOW});
        end
        for (int p = 0; p < 3; p++) begin
            t_parity(fpr_sel_t'(2'(p)), 1'b1);
            t_parity(fpr_sel_t'(2'(p)), 1'b0);
        end
        t_frame(SEL_LOW, 1, 1'b0);
        t_frame(SEL_LOW, 2, 1'b1);
        t_frame(SEL_MID, 2, 1'b0);
        t_frame(SEL_MID, 3, 1'b1);
        t_frame(SEL_HIGH, 4, 1'b0);
        t_frame(SEL_HIGH, 5, 1'b1);
        wrap_up();
    end
endmodule // fpr_ctrl_tb

`default_nettype wire

// ---- fpr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module fpr_host_model
    import fpr_pkg::*;
(
    input wire logic i_clk,
    output logic o_rx_word_valid,
    output logic [CHAR_W-1:0] o_rx_word,
    output logic [7:0] o_dec_byte,
    output logic [2:0] o_dec_status,
    output logic o_tx_valid,
    output logic [7:0] o_tx_byte,
    output logic [1:0] o_tx_char_type,
    output logic o_tx_parity
);
    // Idle at time zero
    initial begin
        {o_rx_word_valid, o_rx_word, o_dec_byte, o_dec_status} = 22'h0;
        {o_tx_valid, o_tx_byte, o_tx_char_type, o_tx_parity} = 12'h0;
    end

    // Back-to-back words; idle lines show the inverse
    task automatic send_burst(input logic [9:0] w, input int k, input logic [7:0] b, input logic [2:0] s);
        @(posedge i_clk);
        o_rx_word_valid <= 1'b1;
        {o_rx_word, o_dec_byte, o_dec_status} <= {w, b, s};
        repeat (k) @(posedge i_clk);
        o_rx_word_valid <= 1'b0;
        {o_rx_word, o_dec_byte, o_dec_status} <= ~{w, b, s};
    endtask

    // One transmit character
    task automatic send_tx(input logic [7:0] b, input logic [1:0] t, input logic p);
        @(posedge i_clk);
        o_tx_valid <= 1'b1;
        {o_tx_byte, o_tx_char_type, o_tx_parity} <= {b, t, p};
        @(posedge i_clk);
        o_tx_valid <= 1'b0;
        {o_tx_byte, o_tx_char_type, o_tx_parity} <= ~{b, t, p};
    endtask
endmodule // fpr_host_model

`default_nettype wire

// ---- fpr_pkg.sv ----
`default_nettype none

package fpr_pkg;

    // Three-level static select, as decoded from its pin
    typedef enum logic [1:0] {
        SEL_LOW  = 2'b00,
        SEL_MID  = 2'b01,
        SEL_HIGH = 2'b10
    } fpr_sel_t;

    // Static configuration word, LSB first: framing, parity, decoder, encoder, rate, half rate
    typedef struct packed {
        logic     tx_half_rate;
        fpr_sel_t rate;
        fpr_sel_t enc;
        fpr_sel_t dec;
        fpr_sel_t parity;
        fpr_sel_t framing;
    } fpr_cfg_t;

    // One received character as handed to the host
    typedef struct packed {
        logic [2:0] status;
        logic [7:0] data;
    } fpr_rx_t;

    // Register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CONFIG = 5'h00;
    localparam logic [4:0] OFF_CONTROL = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

    // Reset values
    localparam logic [10:0] CFG_RESET = 11'h000;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Field positions
    localparam int CFG_W = 11;
    localparam int CTRL_SELF_TEST = 0;
    localparam int CTRL_OUT_EN = 1;
    localparam int CTRL_RX_LATCH = 2;
    localparam int IRQ_PAR_ERR = 0;
    localparam int IRQ_REALIGN = 1;
    localparam int IRQ_BAD_RATE = 2;
    localparam int STAT_OFF_LSB = 0;
    localparam int STAT_READY = 4;
    localparam int STAT_IN_RST = 5;
    localparam int STAT_BAD_RATE = 6;

    // Framing characters (both running disparities) and window sizes
    localparam int CHAR_W = 10;
    localparam logic [9:0] COMMA_NEG = 10'h0FA;
    localparam logic [9:0] COMMA_POS = 10'h305;
    localparam int WINDOW_BITS = 50;
    localparam logic [2:0] SPAN_GAP = 3'(WINDOW_BITS / CHAR_W - 1);
    localparam logic [2:0] HIGH_RUN = 3'h4;
    localparam logic [3:0] SETTLE_CYC = 4'hF;

endpackage

`default_nettype wire
